// File: nov_cfg.svh
// offsets, reset values and scaling constants of the residual overvoltage stage
`ifndef NOV_CFG_SVH
`define NOV_CFG_SVH

// ==========================================================
// register byte offsets
`define OFF_CTRL       12'h000
`define OFF_THRESH     12'h004
`define OFF_TIMING     12'h008
`define OFF_DIAL       12'h00C
`define OFF_NOMINAL    12'h010
`define OFF_VTPRI      12'h014
`define OFF_STATUS     12'h018
`define OFF_RATIO      12'h01C
`define OFF_PRITHR     12'h020
`define OFF_OPTIME     12'h024
`define OFF_REMAIN     12'h028
`define OFF_MEAS       12'h02C

// ==========================================================
// reset values
`define RST_THRESH     14'h07D0
`define RST_DT         19'h00008
`define RST_DIAL       13'h0005
`define RST_NOMINAL    16'h2710
`define RST_VTPRI      20'h04E20

// ==========================================================
// scaling
`define SQRT3_Q        11'h6EE
`define Q10            11'h400
`define PCT_FULL       14'h2710
`define CALC_DIV       2'h3
`define RATIO_ONE      7'h64
`define RELEASE_PCT    7'h61
`define DIAL_SCALE     8'hC8
`define PRI_DEN        21'h1B1034
`define MEAS_MAX       17'h1FFFF
`define RATIO_MAX      17'h1E848
`define PRIM_MAX       24'hFFFFFF
`define T_MAX          19'h57E40
`define DIV_STEPS      6'h30

// ==========================================================
// timing
`define CLK_NS         25
`define CYCLE_NS       5000000

`endif

// File: nov_pkg.sv
// types of the residual overvoltage stage
package nov_pkg;

  typedef enum logic [2:0] {
    MODE_ON      = 3'h0,
    MODE_BLOCKED = 3'h1,
    MODE_TEST    = 3'h2,
    MODE_TESTBLK = 3'h3,
    MODE_OFF     = 3'h4
  } stage_operating_mode_t;

  typedef enum logic [1:0] {
    FORCE_NORMAL  = 2'h0,
    FORCE_START   = 2'h1,
    FORCE_TRIP    = 2'h2,
    FORCE_BLOCKED = 2'h3
  } force_t;

  typedef enum logic [1:0] {
    SRC_AUTO = 2'h0,
    SRC_CALC = 2'h1,
    SRC_AUXA = 2'h2,
    SRC_AUXB = 2'h3
  } src_sel_t;

  typedef enum logic [1:0] {
    ACT_NONE = 2'h0,
    ACT_CALC = 2'h1,
    ACT_AUXA = 2'h2,
    ACT_AUXB = 2'h3
  } active_src_t;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_MEAS  = 6'h02,
    ST_RATIO = 6'h04,
    ST_TIME  = 6'h08,
    ST_PRIM  = 6'h10,
    ST_EVAL  = 6'h20
  } proc_state_t;

  typedef struct packed {
    logic signed [15:0] re;
    logic signed [15:0] im;
  } phasor_t;

  typedef struct packed {
    phasor_t     phase_voltage_a;
    phasor_t     phase_voltage_b;
    phasor_t     phase_voltage_c;
    logic [15:0] aux_channel_a;
    logic [15:0] aux_channel_b;
  } volt_in_t;

  typedef struct packed {
    logic                  allow_stage_operating_mode;
    logic                  ln_connected;
    logic                  aux_b_residual;
    logic                  aux_a_residual;
    logic                  force_enable;
    src_sel_t              src;
    force_t                force_status;
    stage_operating_mode_t mode;
  } ctrl_t;

  typedef struct packed {
    logic        busy;
    logic        done;
    logic [5:0]  cnt;
    logic [32:0] rem;
    logic [47:0] quot;
  } div_st_t;

endpackage

// File: nov_divider.sv
// serial restoring divider, one quotient bit per clock
`timescale 1ns/10ps
`include "nov_cfg.svh"
module nov_divider (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        go,
  input  wire logic [47:0] num,
  input  wire logic [31:0] den,
  output logic             done,
  output logic [47:0]      quot
);
  import nov_pkg::*;

  div_st_t s;
  div_st_t next_s;
  logic [32:0] trial;

  // ==========================================================
  // step logic; zero divisor yields all ones
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    trial = {s.rem[31:0], s.quot[47]};
    if (go) begin
      next_s.busy = 1'b1;
      next_s.cnt  = `DIV_STEPS;
      next_s.rem  = 33'h0;
      next_s.quot = num;
    end else if (s.busy) begin
      if (trial >= {1'b0, den}) begin
        next_s.rem  = trial - {1'b0, den};
        next_s.quot = {s.quot[46:0], 1'b1};
      end else begin
        next_s.rem  = trial;
        next_s.quot = {s.quot[46:0], 1'b0};
      end
      next_s.cnt = s.cnt - 6'h01;
      if (s.cnt == 6'h01) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign done = s.done;
  assign quot = s.quot;
endmodule // nov_divider

// File: neutral_overvoltage_stage.sv
// residual overvoltage pick-up stage with apb register file
`timescale 1ns/10ps
`include "nov_cfg.svh"

// Notes on behaviour
// - derived residual is one third of the three phase voltage sum
// - residual scaled so 57.74 V derived on 100 V system is 100 %
// - only fundamental-frequency values of all five channels are used
// - source setting: auto, derived, aux a, aux b if in residual mode
// - auto prefers derived residual when phase-neutral voltages connected
// - no source available is reported in the active-source status
// - pick-up asserts when measured residual exceeds threshold
// - pick-up releases below 97 % of threshold, or at once in mode off or with no active source
// - threshold in 0.01 % of nominal, default 20.00 %
// - measured to threshold ratio readable with 0.01 resolution
// - operating mode: on, blocked, test, test-blocked, off; default on
// - effective operating mode is readable status
// - forced status normal/start/trip/blocked only with global forcing enabled
// - mode, forcing and source settings are static, not group switched
// - threshold and timing may change live, used without restart
// - primary threshold readable in 0.1 V steps
// - expected operating time in 5 ms steps, recomputed each cycle
// - signed remaining time to trip in 5 ms steps while counting
// - block input sampled each cycle; blocked instead of start when active
module neutral_overvoltage_stage #(
  parameter int CYCLE_CLOCKS = `CYCLE_NS / `CLK_NS
) (
  input  wire logic              CLOCK,
  input  wire logic              RST_B,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [11:0]       PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire nov_pkg::volt_in_t VOLT_IN,
  input  wire logic              BLOCK_IN,
  output logic                   PICKUP,
  output logic                   START,
  output logic                   TRIP,
  output logic                   BLOCKED
);
  import nov_pkg::*;

  typedef struct packed {
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
    ctrl_t                 ctrl;
    logic [13:0]           thr;
    logic [18:0]           dt;
    logic                  inverse_time_mode;
    logic [12:0]           dial;
    logic [15:0]           un;
    logic [19:0]           vtpri;
    logic [17:0]           tick_cnt;
    proc_state_t           fsm;
    stage_operating_mode_t eff_mode;
    active_src_t           active;
    logic [18:0]           mag;
    logic                  blk;
    logic [16:0]           meas;
    logic [16:0]           ratio;
    logic [18:0]           optime;
    logic [23:0]           prim;
    logic signed [19:0]    remain;
    logic                  pickup;
    logic                  start;
    logic                  trip;
    logic                  blocked;
    logic [3:0]            outs;
    logic                  div_go;
    logic [47:0]           div_num;
    logic [31:0]           div_den;
  } st_t;

  st_t         s;
  st_t         next_s;
  logic [1:0]  rst_sync;
  logic        rst_n;
  logic        div_done;
  logic [47:0] div_quot;

  // ==========================================================
  // helpers
  function automatic logic [18:0] isqrt(input logic [37:0] v);
    logic [18:0] r;
    logic [18:0] t;
    r = 19'h0;
    for (int i = 18; i >= 0; i--) begin
      t = r | (19'h1 << i);
      if ({19'h0, t} * {19'h0, t} <= v) begin
        r = t;
      end
    end
    return r;
  endfunction

  function automatic logic [37:0] sq(input logic signed [17:0] x);
    logic [17:0] a;
    a = x[17] ? 18'(-x) : 18'(x);
    return {20'h0, a} * {20'h0, a};
  endfunction

  function automatic logic [18:0] sat19(input logic [47:0] q, input logic [18:0] lim);
    return (q > {29'h0, lim}) ? lim : q[18:0];
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    logic m;
    if (a == `OFF_CTRL) m = 1'b1;
    else if (a == `OFF_THRESH) m = 1'b1;
    else if (a == `OFF_TIMING) m = 1'b1;
    else if (a == `OFF_DIAL) m = 1'b1;
    else if (a == `OFF_NOMINAL) m = 1'b1;
    else if (a == `OFF_VTPRI) m = 1'b1;
    else if (a == `OFF_STATUS) m = 1'b1;
    else if (a == `OFF_RATIO) m = 1'b1;
    else if (a == `OFF_PRITHR) m = 1'b1;
    else if (a == `OFF_OPTIME) m = 1'b1;
    else if (a == `OFF_REMAIN) m = 1'b1;
    else if (a == `OFF_MEAS) m = 1'b1;
    else m = 1'b0;
    return m;
  endfunction

  // ==========================================================
  // reset release
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  nov_divider i_nov_divider (
    .clk   (CLOCK),
    .rst_n (rst_n),
    .go    (s.div_go),
    .num   (s.div_num),
    .den   (s.div_den),
    .done  (div_done),
    .quot  (div_quot)
  );

  // ==========================================================
  // next state
  always_comb begin
    logic               tick;
    logic signed [17:0] sum_re;
    logic signed [17:0] sum_im;
    logic               pk;
    logic               forced;
    next_s = s;
    next_s.div_go = 1'b0;
    tick = 1'b0;
    pk = 1'b0;
    forced = 1'b0;
    // derived residual phasor, scaled by 1/3 in the percent division
    sum_re = 18'(VOLT_IN.phase_voltage_a.re) + 18'(VOLT_IN.phase_voltage_b.re) + 18'(VOLT_IN.phase_voltage_c.re);
    sum_im = 18'(VOLT_IN.phase_voltage_a.im) + 18'(VOLT_IN.phase_voltage_b.im) + 18'(VOLT_IN.phase_voltage_c.im);

    // apb: one wait state, write and read at the ready edge
    if (PSEL && PENABLE && !s.pready) begin
      next_s.pready  = 1'b1;
      next_s.pslverr = !mapped(PADDR);
      // read data only moves on reads
      if (PWRITE) next_s.prdata = s.prdata;
      else if (PADDR == `OFF_CTRL) next_s.prdata = {20'h0, s.ctrl};
      else if (PADDR == `OFF_THRESH) next_s.prdata = {18'h0, s.thr};
      else if (PADDR == `OFF_TIMING) next_s.prdata = {12'h0, s.inverse_time_mode, s.dt};
      else if (PADDR == `OFF_DIAL) next_s.prdata = {19'h0, s.dial};
      else if (PADDR == `OFF_NOMINAL) next_s.prdata = {16'h0, s.un};
      else if (PADDR == `OFF_VTPRI) next_s.prdata = {12'h0, s.vtpri};
      else if (PADDR == `OFF_STATUS) next_s.prdata = {22'h0, s.active, 1'b0, s.eff_mode, s.outs};
      else if (PADDR == `OFF_RATIO) next_s.prdata = {15'h0, s.ratio};
      else if (PADDR == `OFF_PRITHR) next_s.prdata = {8'h0, s.prim};
      else if (PADDR == `OFF_OPTIME) next_s.prdata = {13'h0, s.optime};
      else if (PADDR == `OFF_REMAIN) next_s.prdata = {{12{s.remain[19]}}, s.remain};
      else if (PADDR == `OFF_MEAS) next_s.prdata = {15'h0, s.meas};
      else next_s.prdata = 32'h0;
    end else begin
      next_s.pready  = 1'b0;
      next_s.pslverr = 1'b0;
    end
    // static settings apart from the live group values
    if (PSEL && PENABLE && s.pready && PWRITE) begin
      if (PADDR == `OFF_CTRL) next_s.ctrl = ctrl_t'(PWDATA[11:0]);
      else if (PADDR == `OFF_THRESH) next_s.thr = PWDATA[13:0];
      else if (PADDR == `OFF_TIMING) {next_s.inverse_time_mode, next_s.dt} = PWDATA[19:0];
      else if (PADDR == `OFF_DIAL) next_s.dial = PWDATA[12:0];
      else if (PADDR == `OFF_NOMINAL) next_s.un = PWDATA[15:0];
      else if (PADDR == `OFF_VTPRI) next_s.vtpri = PWDATA[19:0];
    end

    // processing cycle tick
    if (s.tick_cnt == 18'(CYCLE_CLOCKS - 1)) begin
      next_s.tick_cnt = 18'h0;
      tick = 1'b1;
    end else begin
      next_s.tick_cnt = s.tick_cnt + 18'h1;
    end

    case (s.fsm)
      ST_IDLE: begin
        if (tick) begin
          next_s.eff_mode = s.ctrl.allow_stage_operating_mode ? s.ctrl.mode : MODE_ON;
          // explicit aux choice only when configured, else derived if phase-neutral connected, else aux a then aux b for auto, else none
          if (s.ctrl.src == SRC_AUXA && s.ctrl.aux_a_residual) next_s.active = ACT_AUXA;
          else if (s.ctrl.src == SRC_AUXB && s.ctrl.aux_b_residual) next_s.active = ACT_AUXB;
          else if (s.ctrl.ln_connected) next_s.active = ACT_CALC;
          else if (s.ctrl.src == SRC_AUTO && s.ctrl.aux_a_residual) next_s.active = ACT_AUXA;
          else if (s.ctrl.src == SRC_AUTO && s.ctrl.aux_b_residual) next_s.active = ACT_AUXB;
          else next_s.active = ACT_NONE;
          case (next_s.active)
            ACT_CALC: next_s.mag = isqrt(sq(sum_re) + sq(sum_im));
            ACT_AUXA: next_s.mag = {3'h0, VOLT_IN.aux_channel_a};
            ACT_AUXB: next_s.mag = {3'h0, VOLT_IN.aux_channel_b};
            default:  next_s.mag = 19'h0;
          endcase
          next_s.blk = BLOCK_IN;
          // percent of nominal in 0.01 % steps
          next_s.div_num = 48'(next_s.mag) * 48'(`SQRT3_Q) * 48'(`PCT_FULL);
          next_s.div_den = 32'(s.un) * 32'(`Q10) * ((next_s.active == ACT_CALC) ? 32'(`CALC_DIV) : 32'h1);
          next_s.div_go = 1'b1;
          next_s.fsm = ST_MEAS;
        end
      end
      ST_MEAS: begin
        if (div_done) begin
          next_s.meas = (div_quot > 48'(`MEAS_MAX)) ? `MEAS_MAX : div_quot[16:0];
          next_s.div_num = 48'(next_s.meas) * 48'(`RATIO_ONE);
          next_s.div_den = 32'(s.thr);
          next_s.div_go = 1'b1;
          next_s.fsm = ST_RATIO;
        end
      end
      ST_RATIO: begin
        if (div_done) begin
          next_s.ratio = (div_quot > 48'(`RATIO_MAX)) ? `RATIO_MAX : div_quot[16:0];
          // inverse time k/(ratio-1), zero divisor saturates
          next_s.div_num = s.inverse_time_mode ? 48'(s.dial) * 48'(`DIAL_SCALE) : 48'(s.dt);
          next_s.div_den = !s.inverse_time_mode ? 32'h1 :
                           (next_s.ratio > 17'(`RATIO_ONE)) ? 32'(next_s.ratio - 17'(`RATIO_ONE)) : 32'h0;
          next_s.div_go = 1'b1;
          next_s.fsm = ST_TIME;
        end
      end
      ST_TIME: begin
        if (div_done) begin
          next_s.optime = sat19(div_quot, `T_MAX);
          next_s.div_num = 48'(s.thr) * 48'(s.vtpri) * 48'(`Q10);
          next_s.div_den = 32'(`PRI_DEN);
          next_s.div_go = 1'b1;
          next_s.fsm = ST_PRIM;
        end
      end
      ST_PRIM: begin
        if (div_done) begin
          next_s.prim = (div_quot > 48'(`PRIM_MAX)) ? `PRIM_MAX : div_quot[23:0];
          next_s.fsm = ST_EVAL;
        end
      end
      ST_EVAL: begin
        // compare and hysteresis against the live threshold
        if (s.eff_mode == MODE_OFF || s.active == ACT_NONE) begin
          pk = 1'b0;
        end else if (s.pickup) begin
          pk = !(24'(s.meas) * 24'(`RATIO_ONE) < 24'(s.thr) * 24'(`RELEASE_PCT));
        end else begin
          pk = (s.meas > 17'(s.thr));
        end
        next_s.pickup = pk;
        // blocked modes act as a standing block
        if (pk && (s.blk || s.eff_mode == MODE_BLOCKED || s.eff_mode == MODE_TESTBLK)) begin
          next_s.blocked = 1'b1;
          next_s.start = 1'b0;
          next_s.trip = 1'b0;
          next_s.remain = 20'sh0;
        end else if (pk && !s.pickup) begin
          next_s.start = 1'b1;
          next_s.remain = signed'(20'(s.optime));
          next_s.trip = (s.optime == 19'h0);
        end else if (pk && s.start) begin
          if (s.remain > -signed'(20'(`T_MAX))) begin
            next_s.remain = s.remain - 20'sh1;
          end
          next_s.trip = (next_s.remain <= 20'sh0);
        end else if (!pk) begin
          next_s.start = 1'b0;
          next_s.trip = 1'b0;
          next_s.blocked = 1'b0;
          next_s.remain = 20'sh0;
        end
        next_s.fsm = ST_IDLE;
      end
      default: next_s.fsm = ST_IDLE;
    endcase

    // forced outputs with global forcing enabled
    forced = s.ctrl.force_enable && (s.ctrl.force_status != FORCE_NORMAL);
    if (forced) begin
      next_s.outs = {s.ctrl.force_status == FORCE_BLOCKED, s.ctrl.force_status == FORCE_TRIP,
                     s.ctrl.force_status == FORCE_START || s.ctrl.force_status == FORCE_TRIP, next_s.pickup};
    end else begin
      next_s.outs = {next_s.blocked, next_s.trip, next_s.start, next_s.pickup};
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      s          <= '0;
      s.fsm      <= ST_IDLE;
      s.ctrl     <= '0;
      s.thr      <= `RST_THRESH;
      s.dt       <= `RST_DT;
      s.dial     <= `RST_DIAL;
      s.un       <= `RST_NOMINAL;
      s.vtpri    <= `RST_VTPRI;
      s.eff_mode <= MODE_ON;
    end else begin
      s <= next_s;
    end
  end

  assign PRDATA  = s.prdata;
  assign PREADY  = s.pready;
  assign PSLVERR = s.pslverr;
  assign PICKUP  = s.outs[0];
  assign START   = s.outs[1];
  assign TRIP    = s.outs[2];
  assign BLOCKED = s.outs[3];
endmodule // neutral_overvoltage_stage

// File: nov_checker_assertions.sv
// pin-level assertions of the residual overvoltage stage
`timescale 1ns/10ps
module nov_checker (
  input wire logic        CLOCK,
  input wire logic        RST_B,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        PICKUP,
  input wire logic        START,
  input wire logic        TRIP,
  input wire logic        BLOCKED
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);

  // ==========================================================
  // register bus
  sequence s_open; $rose(PSEL && PENABLE); endsequence
  sequence s_answer; PREADY ##1 !PREADY; endsequence
  property p_pready_wait; s_open |-> ##1 s_answer; endproperty
  property p_pready_cause; $rose(PREADY) |-> $past(PSEL && PENABLE); endproperty
  property p_slverr_map; PREADY |-> (PSLVERR == (PADDR > 12'h02C)); endproperty
  property p_rdata_hold; $changed(PRDATA) |-> PREADY && !PWRITE; endproperty
  a_pready_wait: assert property (p_pready_wait) else $error("ready not after one wait state");
  a_pready_cause: assert property (p_pready_cause) else $error("ready without access");
  a_slverr_map: assert property (p_slverr_map) else $error("slave error on wrong address");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved outside a read");

  // ==========================================================
  // stage outputs
  property p_reset_quiet; $rose(RST_B) |-> (!(PICKUP || START || TRIP || BLOCKED || PREADY)) [*2]; endproperty
  property p_outputs_hold;
    $changed({PICKUP, START, TRIP, BLOCKED}) |=> $stable({PICKUP, START, TRIP, BLOCKED}) [*8];
  endproperty
  property p_pickup_onset; $rose(PICKUP) |-> START || BLOCKED; endproperty
  property p_start_excl; !(START && BLOCKED); endproperty
  property p_trip_start; TRIP |-> START; endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
  a_outputs_hold: assert property (p_outputs_hold) else $error("outputs changed between evaluations");
  a_pickup_onset: assert property (p_pickup_onset) else $error("pick-up without start or blocked");
  a_start_excl: assert property (p_start_excl) else $error("start and blocked together");
  a_trip_start: assert property (p_trip_start) else $error("trip without start");
endmodule // nov_checker

bind neutral_overvoltage_stage nov_checker i_nov_checker (
  .CLOCK(CLOCK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PICKUP(PICKUP), .START(START), .TRIP(TRIP),
  .BLOCKED(BLOCKED));

// File: nov_front_end.sv
// measurement front end model: fundamental phasors and aux magnitudes
`timescale 1ns/10ps
module nov_front_end (
  input  wire logic signed [15:0] fault,
  input  wire logic        [15:0] aux_a,
  input  wire logic        [15:0] aux_b,
  output nov_pkg::volt_in_t       volt_in
);
  import nov_pkg::*;
  // balanced 57.74 V set, fault offset on phase a only
  always_comb begin
    volt_in.phase_voltage_a.re = 16'sh168E + fault;
    volt_in.phase_voltage_a.im = 16'sh0000;
    volt_in.phase_voltage_b.re = 16'shF4B9;
    volt_in.phase_voltage_b.im = 16'shEC78;
    volt_in.phase_voltage_c.re = 16'shF4B9;
    volt_in.phase_voltage_c.im = 16'sh1388;
    volt_in.aux_channel_a      = aux_a;
    volt_in.aux_channel_b      = aux_b;
  end
endmodule // nov_front_end

// File: tb_neutral_overvoltage_stage.sv
// self-checking bench of the residual overvoltage stage
`timescale 1ns/10ps
`include "nov_cfg.svh"
module tb_neutral_overvoltage_stage;
  import nov_pkg::*;
  localparam int CYC = 300;
  logic               clock   = 1'b0;
  logic               rst_b   = 1'b0;
  logic               psel    = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite  = 1'b0;
  logic [11:0]        paddr   = 12'h000;
  logic [31:0]        pwdata  = 32'h0;
  logic               block   = 1'b0;
  logic signed [15:0] fault   = 16'sh0000;
  logic [15:0]        aux_a   = 16'h0000;
  logic [15:0]        aux_b   = 16'h0000;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               pickup;
  logic               start;
  logic               trip;
  logic               blocked;
  volt_in_t           volt;
  logic [31:0]        rd_data;
  logic               rd_err;
  int                 mismatches = 0;
  int                 checks     = 0;

  nov_front_end i_nov_front_end (.fault(fault), .aux_a(aux_a), .aux_b(aux_b), .volt_in(volt));
  neutral_overvoltage_stage #(.CYCLE_CLOCKS(CYC)) i_neutral_overvoltage_stage (
    .CLOCK(clock), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .VOLT_IN(volt),
    .BLOCK_IN(block), .PICKUP(pickup), .START(start), .TRIP(trip), .BLOCKED(blocked));

  initial begin
    forever #12.5 clock = ~clock;
  end

  // ==========================================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic near(input logic [31:0] seen, input logic [31:0] lo, input logic [31:0] hi);
    checks++;
    if (((seen >= lo) && (seen <= hi)) !== 1'b1) begin
      mismatches++;
      $display("ERROR %0t: got %h want %h..%h", $time, seen, lo, hi);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
    int n;
    n = 0;
    @(posedge clock);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= addr;
    pwdata <= wdata;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    check({31'h0, pready}, 32'h1);
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] addr, input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    check(rd_data & mask, exp);
  endtask
  task automatic settle;
    repeat (2 * CYC + 50) @(posedge clock);
  endtask
  task automatic drive(input logic signed [15:0] f, input logic [15:0] a, input logic b);
    @(posedge clock);
    fault <= f;
    aux_a <= a;
    block <= b;
    settle();
  endtask
  task automatic pins(input logic [3:0] exp);
    check({28'h0, pickup, start, trip, blocked}, {28'h0, exp});
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    logic [11:0] a [6];
    logic [31:0] v [6];
    a = '{`OFF_CTRL, `OFF_THRESH, `OFF_TIMING, `OFF_DIAL, `OFF_NOMINAL, `OFF_VTPRI};
    v = '{32'h0, 32'h7D0, 32'h8, 32'h5, 32'h2710, 32'h4E20};
    for (int i = 0; i < 6; i++) rd_chk(a[i], 32'hFFFFFFFF, v[i]);
    apb(1'b1, 12'h030, 32'hFFFFFFFF);
    check({31'h0, rd_err}, 32'h1);
    apb(1'b0, 12'h030, 32'h0);
    check(rd_data, 32'h0);
    pins(4'h0);
  endtask
  task automatic t_sources;
    logic [31:0] c [5];
    logic [31:0] s [5];
    c = '{32'h400, 32'h440, 32'h140, 32'h260, 32'h020};
    s = '{32'h100, 32'h100, 32'h200, 32'h300, 32'h000};
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, `OFF_CTRL, c[i]);
      settle();
      rd_chk(`OFF_STATUS, 32'h300, s[i]);
    end
  endtask
  task automatic t_pickup;
    apb(1'b1, `OFF_CTRL, 32'h140);
    drive(16'sh0000, 16'h046A, 1'b0);
    pins(4'h0);
    drive(16'sh0000, 16'h04BD, 1'b0);
    pins(4'hC);
    apb(1'b0, `OFF_MEAS, 32'h0);
    near(rd_data, 32'd2096, 32'd2106);
    apb(1'b0, `OFF_RATIO, 32'h0);
    near(rd_data, 32'd104, 32'd106);
    apb(1'b0, `OFF_PRITHR, 32'h0);
    near(rd_data, 32'd23090, 32'd23098);
    rd_chk(`OFF_OPTIME, 32'hFFFFFFFF, 32'h8);
    repeat (9 * CYC) @(posedge clock);
    pins(4'hE);
    drive(16'sh0000, 16'h046A, 1'b0);
    check({31'h0, pickup}, 32'h1);
    drive(16'sh0000, 16'h044C, 1'b0);
    pins(4'h0);
    drive(16'sh0000, 16'h04BD, 1'b0);
    apb(1'b1, `OFF_THRESH, 32'h9C4);
    settle();
    check({31'h0, pickup}, 32'h0);
    apb(1'b1, `OFF_THRESH, 32'h7D0);
    apb(1'b1, `OFF_TIMING, 32'h80000);
    settle();
    rd_chk(`OFF_OPTIME, 32'hFFFFFFFF, 32'hC8);
  endtask
  task automatic t_derived;
    apb(1'b1, `OFF_CTRL, 32'h400);
    drive(16'sh43AA, 16'h0000, 1'b0);
    apb(1'b0, `OFF_MEAS, 32'h0);
    near(rd_data, 32'd9990, 32'd10015);
    check({31'h0, pickup}, 32'h1);
    drive(16'sh0000, 16'h0000, 1'b0);
    drive(16'sh43AA, 16'h0000, 1'b1);
    pins(4'h9);
    drive(16'sh0000, 16'h0000, 1'b0);
  endtask
  task automatic t_modes;
    drive(16'sh43AA, 16'h0000, 1'b0);
    for (int m = 0; m < 5; m++) begin
      apb(1'b1, `OFF_CTRL, 32'hC00 | m);
      settle();
      rd_chk(`OFF_STATUS, 32'h70, m << 4);
      if (m == 4) pins(4'h0);
    end
  endtask
  task automatic t_force;
    logic [2:0] e [4];
    e = '{3'h0, 3'h4, 3'h6, 3'h1};
    apb(1'b1, `OFF_CTRL, 32'h410);
    drive(16'sh0000, 16'h0000, 1'b0);
    pins(4'h0);
    for (int f = 1; f < 4; f++) begin
      apb(1'b1, `OFF_CTRL, 32'h480 | (f << 3));
      settle();
      check({29'h0, start, trip, blocked}, {29'h0, e[f]});
    end
  endtask

  // ==========================================================
  // sequence and verdict
  task automatic wrap_up;
    if (mismatches == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    t_reset();
    t_sources();
    t_pickup();
    t_derived();
    t_modes();
    t_force();
    wrap_up();
  end

  initial begin
    repeat (40000) @(posedge clock);
    mismatches++;
    wrap_up();
  end
endmodule // tb_neutral_overvoltage_stage
